// file: ptc_timer_top.sv
// timer counter top: avalon-mm register slave and the 16-bit up/down counter
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps

// Operation
// - sixteen-bit counter steps up or down once per count clock tick
// - two-bit direction field plus single-cycle bit give six modes
// - repeat modes run until software stops; single-cycle modes stop themselves
// - limit register bounds count range zero to limit
// - preset clears counter in up modes, loads limit in down mode
// - counting up, counter clears to zero when passing the limit
// - writing run one starts counting; stopping depends on mode
// - active status bit reads one while running, zero while idle
// - direction status reads one counting up, zero counting down
// - repeat up wraps past limit to zero until run cleared
// - limit above count becomes new limit; below count clears counter
// - single-cycle up returns to zero past limit, then stops
// - repeat down reloads limit on underflow; new limit after underflow
// - single-cycle down reloads limit on underflow, then stops
// - repeat up/down runs zero to limit and back, until run cleared
// - limit change while descending does not disturb descent to zero
// - single-cycle up/down stops reaching zero while counting down
// - limit-reached and zero-reached event flags set on those counts
module ptc_timer_top
  import ptc_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input wire logic mclk_i, // 250 mhz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [4:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [3:0] avs_byteenable_i, // write byte lanes
  input wire logic [31:0] avs_writedata_i, // write data
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // high until the answer stands
  output logic [15:0] count_value_o, // current count
  output logic counter_active_o, // counter running
  output logic count_up_o, // counting upward
  output logic limit_event_o, // pulse: count reached limit
  output logic zero_event_o // pulse: count reached zero
);

  ptc_ctrl_type ctrl_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic up_ff;
  logic nxt_up;
  logic stop_req;
  logic hit_limit;
  logic hit_zero;
  logic [1:0] event_flags_ff;
  logic req;
  logic do_wr;
  logic preset_p;
  logic run_wr;
  logic tick;
  logic ticking;
  logic [15:0] limit_value;
  logic [15:0] limit_pend;
  logic limit_update_busy;
  logic [31:0] rd_word;
  logic [31:0] limit_merge;
  ptc_dir_type pre_dir;

  // ==========================================================================
  // elaboration check
  generate
    if (CNT_W != 16)
    begin : g_bad_width
      $error("ptc_timer_top supports CNT_W of 16 only");
    end
  endgenerate

  // ==========================================================================
  // bus helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      be_merge[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
  endfunction

  // a write takes effect at the edge where waitrequest is seen low
  assign req = avs_read_i || avs_write_i;
  assign do_wr = avs_write_i && !avs_waitrequest_o;
  assign preset_p = do_wr && (avs_address_i == PTC_OFS_CTRL) && avs_byteenable_i[0]
                    && avs_writedata_i[PTC_CTRL_PRESET_BIT];
  assign run_wr = do_wr && (avs_address_i == PTC_OFS_CTRL) && avs_byteenable_i[0];
  // preset follows the direction written with it, so mode and preset may share a write
  assign pre_dir = ptc_dir_type'(avs_writedata_i[PTC_CTRL_DIR_LSB +: 2]);
  assign limit_merge = be_merge({16'h0000, limit_pend}, avs_writedata_i, avs_byteenable_i);

  // one wait state: waitrequest drops for exactly one cycle per request
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !(req && avs_waitrequest_o);
  end

  // ==========================================================================
  // read multiplexer; preset bit always reads back zero
  always_comb
  begin
    rd_word = PTC_UNMAPPED_RD;
    case (avs_address_i)
      PTC_OFS_CTRL:
      begin
        rd_word[PTC_CTRL_ENABLE_BIT] = ctrl_ff.module_enable;
        rd_word[PTC_CTRL_RUN_BIT] = ctrl_ff.run;
        rd_word[PTC_CTRL_DIR_LSB +: 2] = ctrl_ff.count_direction_sel;
        rd_word[PTC_CTRL_SINGLE_BIT] = ctrl_ff.single_cycle_sel;
        rd_word[PTC_CTRL_DIV_LSB +: 4] = ctrl_ff.div_sel;
      end
      PTC_OFS_LIMIT: rd_word[15:0] = limit_pend;
      PTC_OFS_COUNT: rd_word[15:0] = count_ff;
      PTC_OFS_STATUS:
      begin
        rd_word[PTC_STAT_ACTIVE_BIT] = counter_active_o;
        rd_word[PTC_STAT_UP_BIT] = up_ff;
        rd_word[PTC_STAT_BUSY_BIT] = limit_update_busy;
      end
      PTC_OFS_EVENT: rd_word[1:0] = event_flags_ff;
      default: rd_word = PTC_UNMAPPED_RD;
    endcase
  end

  // read data captured while waitrequest is still high, stands with it low
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      avs_readdata_o <= PTC_UNMAPPED_RD;
    else if (avs_read_i && avs_waitrequest_o)
      avs_readdata_o <= rd_word;
  end

  // ==========================================================================
  // control register; a software run write beats a same-cycle self stop
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      ctrl_ff <= PTC_CTRL_RST;
    else if (run_wr)
    begin
      ctrl_ff.module_enable <= avs_writedata_i[PTC_CTRL_ENABLE_BIT];
      ctrl_ff.run <= avs_writedata_i[PTC_CTRL_RUN_BIT];
      ctrl_ff.count_direction_sel <= ptc_dir_type'(avs_writedata_i[PTC_CTRL_DIR_LSB +: 2]);
      ctrl_ff.single_cycle_sel <= avs_writedata_i[PTC_CTRL_SINGLE_BIT];
      if (avs_byteenable_i[1])
        ctrl_ff.div_sel <= avs_writedata_i[PTC_CTRL_DIV_LSB +: 4];
    end
    else if (stop_req)
      ctrl_ff.run <= 1'b0;
  end

  // ==========================================================================
  // count clock enable and limit holder
  ptc_tick_div #(.DIV_W(4)) u_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .en_i(ctrl_ff.module_enable),
    .sel_i(ctrl_ff.div_sel),
    .tick_o(tick)
  );

  ptc_limit_sync u_limit (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_i(do_wr && (avs_address_i == PTC_OFS_LIMIT)),
    .data_i(limit_merge[15:0]),
    .tick_i(tick),
    .running_i(counter_active_o),
    .pend_o(limit_pend),
    .limit_o(limit_value),
    .busy_o(limit_update_busy)
  );

  assign ticking = tick && ctrl_ff.run && ctrl_ff.module_enable;

  // ==========================================================================
  // next count; preset has priority over a tick in the same cycle
  always_comb
  begin
    nxt_count = count_ff;
    nxt_up = up_ff;
    stop_req = 1'b0;
    if (preset_p)
    begin
      // down mode loads the limit, the other modes clear
      if (pre_dir == PTC_DIR_DOWN)
        nxt_count = limit_value;
      else
        nxt_count = 16'h0000;
      nxt_up = (pre_dir != PTC_DIR_DOWN);
    end
    else if (ticking)
    begin
      case (ctrl_ff.count_direction_sel)
        PTC_DIR_DOWN:
        begin
          nxt_up = 1'b0;
          if (count_ff == 16'h0000)
          begin
            nxt_count = limit_value;
            stop_req = ctrl_ff.single_cycle_sel;
          end
          else
            nxt_count = count_ff - 16'h0001;
        end
        PTC_DIR_UPDN:
        begin
          if (up_ff)
          begin
            if (count_ff > limit_value)
              nxt_count = 16'h0000;
            else if (count_ff == limit_value)
            begin
              nxt_up = 1'b0;
              nxt_count = (count_ff == 16'h0000) ? 16'h0000 : count_ff - 16'h0001;
            end
            else
              nxt_count = count_ff + 16'h0001;
          end
          else if (count_ff <= 16'h0001)
          begin
            // descent ignores the limit, so a new limit waits for the climb
            nxt_count = 16'h0000;
            nxt_up = 1'b1;
            stop_req = ctrl_ff.single_cycle_sel;
          end
          else
            nxt_count = count_ff - 16'h0001;
        end
        default:
        begin
          // reserved direction code counts up
          nxt_up = 1'b1;
          if (count_ff >= limit_value)
          begin
            nxt_count = 16'h0000;
            stop_req = ctrl_ff.single_cycle_sel;
          end
          else
            nxt_count = count_ff + 16'h0001;
        end
      endcase
    end
  end

  // events only come from real count steps, never from a preset
  assign hit_limit = ticking && !preset_p && (nxt_count == limit_value);
  assign hit_zero = ticking && !preset_p && (nxt_count == 16'h0000);

  // counter state
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      count_ff <= PTC_COUNT_RST;
      up_ff <= 1'b1;
    end
    else
    begin
      count_ff <= nxt_count;
      up_ff <= nxt_up;
    end
  end

  // sticky event flags, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      event_flags_ff <= 2'h0;
    else
    begin
      if (do_wr && (avs_address_i == PTC_OFS_EVENT) && avs_byteenable_i[0])
        event_flags_ff <= event_flags_ff & ~avs_writedata_i[1:0];
      if (hit_limit)
        event_flags_ff[PTC_EVT_LIMIT_BIT] <= 1'b1;
      if (hit_zero)
        event_flags_ff[PTC_EVT_ZERO_BIT] <= 1'b1;
    end
  end

  // registered outputs
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      count_value_o <= PTC_COUNT_RST;
      counter_active_o <= 1'b0;
      count_up_o <= 1'b1;
      limit_event_o <= 1'b0;
      zero_event_o <= 1'b0;
    end
    else
    begin
      count_value_o <= nxt_count;
      counter_active_o <= ctrl_ff.run && ctrl_ff.module_enable;
      count_up_o <= nxt_up;
      limit_event_o <= hit_limit;
      zero_event_o <= hit_zero;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_up_top;
    ticking && !preset_p && ctrl_ff.count_direction_sel == PTC_DIR_UP && count_ff >= limit_value;
  endsequence

  sequence s_down_under;
    ticking && !preset_p && ctrl_ff.count_direction_sel == PTC_DIR_DOWN && count_ff == 16'h0000;
  endsequence

  chk_up_wrap_zero: assert property (s_up_top |=> count_ff == 16'h0000)
    else $error("up count did not wrap to zero");
  chk_up_step_one: assert property (ticking && !preset_p && ctrl_ff.count_direction_sel == PTC_DIR_UP
      && count_ff < limit_value |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("up count did not step by one");
  chk_single_up_stop: assert property (s_up_top ##0 ctrl_ff.single_cycle_sel && !run_wr
      |=> !ctrl_ff.run ##1 !counter_active_o)
    else $error("single-cycle up did not stop");
  chk_down_reload: assert property (s_down_under |=> count_ff == $past(limit_value))
    else $error("down underflow did not reload limit");
  chk_preset_down: assert property (preset_p && pre_dir == PTC_DIR_DOWN
      |=> count_ff == $past(limit_value))
    else $error("preset in down mode did not load limit");
  chk_active_flag: assert property (ctrl_ff.run && ctrl_ff.module_enable |=> counter_active_o)
    else $error("active status not shown while running");
  chk_down_dir: assert property (ticking && !preset_p && ctrl_ff.count_direction_sel == PTC_DIR_DOWN
      |=> !count_up_o)
    else $error("direction status not low while counting down");
  chk_updn_turn: assert property (ticking && !preset_p && ctrl_ff.count_direction_sel == PTC_DIR_UPDN
      && up_ff && count_ff == limit_value && limit_value != 16'h0000 |=> !up_ff)
    else $error("up/down did not turn at limit");
  chk_zero_flag: assert property (zero_event_o |-> event_flags_ff[PTC_EVT_ZERO_BIT])
    else $error("zero event did not set its flag");

endmodule // ptc_timer_top

// file: ptc_pkg.sv
// package: register map, field layout, reset values and types of the timer counter
package ptc_pkg;

  // ==========================================================================
  // register byte offsets on the avalon slave
  localparam logic [4:0] PTC_OFS_CTRL = 5'h00;
  localparam logic [4:0] PTC_OFS_LIMIT = 5'h04;
  localparam logic [4:0] PTC_OFS_COUNT = 5'h08;
  localparam logic [4:0] PTC_OFS_STATUS = 5'h0c;
  localparam logic [4:0] PTC_OFS_EVENT = 5'h10;

  // ==========================================================================
  // control register field positions
  localparam int PTC_CTRL_ENABLE_BIT = 0;
  localparam int PTC_CTRL_PRESET_BIT = 1;
  localparam int PTC_CTRL_RUN_BIT = 2;
  localparam int PTC_CTRL_DIR_LSB = 4;
  localparam int PTC_CTRL_SINGLE_BIT = 6;
  localparam int PTC_CTRL_DIV_LSB = 8;

  // status and event field positions
  localparam int PTC_STAT_ACTIVE_BIT = 0;
  localparam int PTC_STAT_UP_BIT = 1;
  localparam int PTC_STAT_BUSY_BIT = 2;
  localparam int PTC_EVT_LIMIT_BIT = 0;
  localparam int PTC_EVT_ZERO_BIT = 1;

  // ==========================================================================
  // reset values and bus answers
  localparam logic [15:0] PTC_LIMIT_RST = 16'hffff;
  localparam logic [15:0] PTC_COUNT_RST = 16'h0000;
  localparam logic [3:0] PTC_DIV_RST = 4'h0;
  localparam logic [31:0] PTC_UNMAPPED_RD = 32'h0000_0000;

  // ==========================================================================
  // count direction selection
  typedef enum logic [1:0] {
    PTC_DIR_UP = 2'h0,
    PTC_DIR_DOWN = 2'h1,
    PTC_DIR_UPDN = 2'h2,
    PTC_DIR_RSVD = 2'h3
  } ptc_dir_type;

  // control register carrier
  typedef struct packed {
    logic [3:0] div_sel;
    logic single_cycle_sel;
    ptc_dir_type count_direction_sel;
    logic run;
    logic module_enable;
  } ptc_ctrl_type;

  localparam ptc_ctrl_type PTC_CTRL_RST = '{PTC_DIV_RST, 1'b0, PTC_DIR_UP, 1'b0, 1'b0};

endpackage

// file: ptc_tick_div.sv
// count clock enable divider: one pulse every 2**div_sel cycles
`timescale 1ns/100ps
module ptc_tick_div
  import ptc_pkg::*;
#(
  parameter int DIV_W = 4
)(
  input wire logic mclk_i, // 250 mhz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic en_i, // module enable
  input wire logic [3:0] sel_i, // log2 of division ratio
  output logic tick_o // one-cycle count clock enable
);

  logic [15:0] div_ff;

  // ==========================================================================
  // mask of low bits that must all be one for a tick
  function automatic logic [15:0] low_mask(input logic [3:0] s);
    low_mask = 16'hffff >> (5'h10 - {1'b0, s});
  endfunction

  // free-running divider; held at zero while disabled so ticks restart aligned
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !en_i)
      div_ff <= 16'h0000;
    else
      div_ff <= div_ff + 16'h0001;
  end

  // tick when the selected low bits are all ones
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      tick_o <= 1'b0;
    else
      tick_o <= en_i && ((div_ff & low_mask(sel_i)) == low_mask(sel_i));
  end

  generate
    if (DIV_W != 4)
    begin : g_bad_div
      $error("ptc_tick_div supports DIV_W of 4 only");
    end
  endgenerate

endmodule // ptc_tick_div

// file: ptc_limit_sync.sv
// limit value holder: a written limit is applied on the next count tick, or on the next clock while the counter is stopped
`timescale 1ns/100ps
module ptc_limit_sync
  import ptc_pkg::*;
(
  input wire logic mclk_i, // 250 mhz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wr_i, // software writes a new limit
  input wire logic [15:0] data_i, // new limit value
  input wire logic tick_i, // count clock enable
  input wire logic running_i, // counter is active
  output logic [15:0] pend_o, // value last written by software
  output logic [15:0] limit_o, // limit in force for the counter
  output logic busy_o // update not yet applied
);

  // ==========================================================================
  // pending value and busy flag; while the counter runs the update waits for a count clock edge so the
  // counter never sees a limit change between two of its own steps
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pend_o <= PTC_LIMIT_RST;
      limit_o <= PTC_LIMIT_RST;
      busy_o <= 1'b0;
    end
    else if (wr_i)
    begin
      pend_o <= data_i;
      busy_o <= 1'b1;
    end
    else if (busy_o && (tick_i || !running_i))
    begin
      limit_o <= pend_o;
      busy_o <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  chk_limit_apply: assert property (busy_o && !wr_i && tick_i |=> !busy_o && limit_o == $past(pend_o))
    else $error("pending limit not applied on tick");

endmodule // ptc_limit_sync

// file: ptc_timer_top_bench.sv
// self-checking bench for the timer counter top, driven through its avalon slave
`timescale 1ns/100ps

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module ptc_timer_top_bench;
  import ptc_pkg::*;

  // ==========================================================================
  // stimulus table
  typedef struct packed {
    logic [1:0] dir;
    logic sgl;
    logic [15:0] lim;
    logic [15:0] fin;
    logic [1:0] up;
  } ptc_row_type;

  // up field: 1 expects up status, 0 down, 2 not checked (direction turns)
  localparam ptc_row_type ROWS [7] = '{
    '{2'h0, 1'b0, 16'h0005, 16'h0000, 2'h1},
    '{2'h1, 1'b0, 16'h0006, 16'h0000, 2'h0},
    '{2'h2, 1'b0, 16'h0004, 16'h0000, 2'h2},
    '{2'h3, 1'b0, 16'h0004, 16'h0000, 2'h1},
    '{2'h0, 1'b1, 16'h0007, 16'h0000, 2'h1},
    '{2'h1, 1'b1, 16'h0005, 16'h0005, 2'h0},
    '{2'h2, 1'b1, 16'h0003, 16'h0000, 2'h2}};

  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [15:0] count_value_o;
  logic counter_active_o;
  logic count_up_o;
  logic limit_event_o;
  logic zero_event_o;
  int err_count = 0;
  int num_checks = 0;
  logic mon_clr = 1'b0;
  logic [15:0] max_seen = 16'h0;
  int lim_evts = 0;
  int zero_evts = 0;
  logic [31:0] q;
  logic [15:0] v;
  int n;

  ptc_timer_top ptc_timer_top_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .count_value_o(count_value_o), .counter_active_o(counter_active_o),
    .count_up_o(count_up_o), .limit_event_o(limit_event_o), .zero_event_o(zero_event_o));

  // 250 mhz clock
  initial
  begin
    forever #2 mclk_i = ~mclk_i;
  end

  // ==========================================================================
  // monitor: peak count and event pulses since the last clear
  always @(posedge mclk_i)
  begin
    if (mon_clr)
    begin
      max_seen <= 16'h0;
      lim_evts <= 0;
      zero_evts <= 0;
    end
    else
    begin
      if (count_value_o > max_seen) max_seen <= count_value_o;
      if (limit_event_o === 1'b1) lim_evts <= lim_evts + 1;
      if (zero_event_o === 1'b1) zero_evts <= zero_evts + 1;
    end
  end

  // ==========================================================================
  // closing report, the only place the run ends
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tmo;
    err_count++;
    $display("[FAIL] bounded wait expected 1 seen 0");
    results();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
  endtask

  task automatic clr;
    mon_clr <= 1'b1;
    @(posedge mclk_i);
    mon_clr <= 1'b0;
  endtask

  // one avalon transfer: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] rq);
    int k;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    k = 0;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (avs_waitrequest_o !== 1'b0 && k < 30);
    rq = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) tmo();
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dq;
    bus(1'b1, a, d, dq);
  endtask

  // control word with module enable always set
  function automatic logic [31:0] ctl(input logic run, input logic pre, input logic [1:0] dir,
                                      input logic sgl, input logic [3:0] dv);
    logic [31:0] c;
    c = 32'h0;
    c[PTC_CTRL_ENABLE_BIT] = 1'b1;
    c[PTC_CTRL_PRESET_BIT] = pre;
    c[PTC_CTRL_RUN_BIT] = run;
    c[PTC_CTRL_DIR_LSB +: 2] = dir;
    c[PTC_CTRL_SINGLE_BIT] = sgl;
    c[PTC_CTRL_DIV_LSB +: 4] = dv;
    return c;
  endfunction

  // ==========================================================================
  // main sequence
  initial
  begin
    cyc(4);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      wr(PTC_OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, 1'b0, 4'h0));
      wr(PTC_OFS_LIMIT, {16'h0, ROWS[i].lim});
      wr(PTC_OFS_EVENT, 32'h3);
      wr(PTC_OFS_CTRL, ctl(1'b0, 1'b1, ROWS[i].dir, ROWS[i].sgl, 4'h0));
      cyc(2);
      v = (ROWS[i].dir == PTC_DIR_DOWN) ? ROWS[i].lim : 16'h0;
      `CHK("preset count", v, count_value_o)
      bus(1'b0, PTC_OFS_CTRL, 32'h0, q);
      `CHK("preset readback", 1'b0, q[PTC_CTRL_PRESET_BIT])
      clr();
      wr(PTC_OFS_CTRL, ctl(1'b1, 1'b0, ROWS[i].dir, ROWS[i].sgl, 4'h0));
      if (ROWS[i].sgl)
      begin
        // active status lags the run write by a cycle: see it rise before waiting for the stop
        for (n = 0; n < 10 && counter_active_o !== 1'b1; n++) cyc(1);
        if (n >= 10) tmo();
        for (n = 0; n < 100 && counter_active_o !== 1'b0; n++) cyc(1);
        if (n >= 100) tmo();
        cyc(5);
        `CHK("single end count", ROWS[i].fin, count_value_o)
        `CHK("single zero events", 1, zero_evts)
        `CHK("single limit events", 1, lim_evts)
      end
      else
      begin
        cyc(40);
        bus(1'b0, PTC_OFS_STATUS, 32'h0, q);
        `CHK("active bit", 1'b1, q[PTC_STAT_ACTIVE_BIT])
        if (ROWS[i].up != 2'h2) `CHK("up bit", ROWS[i].up[0], q[PTC_STAT_UP_BIT])
        `CHK("peak count", ROWS[i].lim, max_seen)
        `CHK("repeat keeps going", 1'b1, lim_evts > 1 && zero_evts > 1)
        wr(PTC_OFS_CTRL, ctl(1'b0, 1'b0, ROWS[i].dir, 1'b0, 4'h0));
        cyc(2);
        `CHK("stopped", 1'b0, counter_active_o)
      end
      bus(1'b0, PTC_OFS_EVENT, 32'h0, q);
      `CHK("event flags", 32'h3, q)
      wr(PTC_OFS_EVENT, 32'h3);
      bus(1'b0, PTC_OFS_EVENT, 32'h0, q);
      `CHK("flags cleared", 32'h0, q)
      $display("row %0d done", i);
    end

    // lower limit below the running up count clears it, then counts to the new limit
    wr(PTC_OFS_LIMIT, 32'h00c8);
    wr(PTC_OFS_CTRL, ctl(1'b0, 1'b1, PTC_DIR_UP, 1'b0, 4'h0));
    wr(PTC_OFS_CTRL, ctl(1'b1, 1'b0, PTC_DIR_UP, 1'b0, 4'h0));
    for (n = 0; n < 400 && count_value_o < 16'h0064; n++) cyc(1);
    if (n >= 400) tmo();
    bus(1'b0, PTC_OFS_STATUS, 32'h0, q);
    `CHK("limit busy idle", 1'b0, q[PTC_STAT_BUSY_BIT])
    wr(PTC_OFS_LIMIT, 32'h0014);
    cyc(3);
    clr();
    cyc(60);
    `CHK("peak after lower limit", 16'h0014, max_seen)
    wr(PTC_OFS_CTRL, ctl(1'b0, 1'b0, PTC_DIR_UP, 1'b0, 4'h0));
    $display("limit lowered while counting up done");

    // limit changed while counting down applies only after underflow
    wr(PTC_OFS_LIMIT, 32'h0032);
    wr(PTC_OFS_CTRL, ctl(1'b0, 1'b1, PTC_DIR_DOWN, 1'b0, 4'h0));
    wr(PTC_OFS_CTRL, ctl(1'b1, 1'b0, PTC_DIR_DOWN, 1'b0, 4'h0));
    for (n = 0; n < 100 && count_value_o > 16'h001e; n++) cyc(1);
    if (n >= 100) tmo();
    wr(PTC_OFS_LIMIT, 32'h000a);
    cyc(2);
    `CHK("descent kept", 1'b1, count_value_o > 16'h000a && count_value_o < 16'h001e)
    for (n = 0; n < 60 && count_value_o !== 16'h0; n++) cyc(1);
    if (n >= 60) tmo();
    cyc(2);
    clr();
    cyc(40);
    `CHK("reload with new limit", 16'h000a, max_seen)
    $display("limit changed while counting down done");

    // divided count clock: one step every four clocks
    wr(PTC_OFS_LIMIT, 32'h0064);
    wr(PTC_OFS_CTRL, ctl(1'b0, 1'b1, PTC_DIR_UP, 1'b0, 4'h2));
    wr(PTC_OFS_CTRL, ctl(1'b1, 1'b0, PTC_DIR_UP, 1'b0, 4'h2));
    v = count_value_o;
    for (n = 0; n < 20 && count_value_o === v; n++) cyc(1);
    v = count_value_o;
    for (n = 0; n < 20 && count_value_o === v; n++) cyc(1);
    `CHK("tick spacing", 4, n)
    `CHK("step size", v + 16'h1, count_value_o)
    $display("divided count clock done");

    // stopped counter: two reads of the count agree and match the count pins
    wr(PTC_OFS_CTRL, ctl(1'b0, 1'b0, PTC_DIR_UP, 1'b0, 4'h2));
    cyc(2);
    v = count_value_o;
    bus(1'b0, PTC_OFS_COUNT, 32'h0, q);
    `CHK("count read", {16'h0, v}, q)
    bus(1'b0, PTC_OFS_COUNT, 32'h0, q);
    `CHK("count reread", {16'h0, v}, q)
    wr(PTC_OFS_CTRL, ctl(1'b1, 1'b0, PTC_DIR_UP, 1'b0, 4'h2));
    $display("count read done");

    // reset in mid-run, then reset values and unmapped access
    cyc(7);
    rst_i <= 1'b1;
    cyc(4);
    rst_i <= 1'b0;
    cyc(1);
    `CHK("reset count", PTC_COUNT_RST, count_value_o)
    `CHK("reset active", 1'b0, counter_active_o)
    `CHK("reset up", 1'b1, count_up_o)
    bus(1'b0, PTC_OFS_CTRL, 32'h0, q);
    `CHK("reset ctrl", 32'h0, q)
    bus(1'b0, PTC_OFS_LIMIT, 32'h0, q);
    `CHK("reset limit", {16'h0, PTC_LIMIT_RST}, q)
    bus(1'b0, PTC_OFS_STATUS, 32'h0, q);
    `CHK("reset status", 32'h1 << PTC_STAT_UP_BIT, q)
    bus(1'b0, PTC_OFS_EVENT, 32'h0, q);
    `CHK("reset events", 32'h0, q)
    wr(5'h14, 32'hffff_ffff);
    bus(1'b0, 5'h14, 32'h0, q);
    `CHK("unmapped read", PTC_UNMAPPED_RD, q)
    bus(1'b0, PTC_OFS_CTRL, 32'h0, q);
    `CHK("ctrl after unmapped write", 32'h0, q)
    // lane 1 disabled: the divider field must keep its value
    avs_byteenable_i <= 4'h1;
    wr(PTC_OFS_CTRL, 32'h0000_0f00);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, PTC_OFS_CTRL, 32'h0, q);
    `CHK("masked lane write", 32'h0, q)
    $display("reset and unmapped access done");
    results();
  end

endmodule // ptc_timer_top_bench
